// >>> core/fps_sequencer.sv
// Purpose: Four rail power sequencer with AXI4-Lite control.
// Assumes: Pins synchronous to core_clk_i; gate feedback from comparators.
// Notes: Delays count 1 us ticks; zero means immediate.
`timescale 1ns/1ps
module fps_sequencer #(
  parameter int SETTLE_CYC_P = fps_pkg::SETTLE_CYC,
  parameter int DONE_CYC_P = fps_pkg::DONE_CYC,
  parameter int IND_DONE_CYC_P = fps_pkg::IND_DONE_CYC,
  parameter int FILTER_CYC_P = fps_pkg::FILTER_CYC
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic [fps_pkg::NCH-1:0] uv_ok_i,
  input wire logic [1:0] enable_i,
  input wire logic [fps_pkg::NCH-1:0] gate_full_i,
  input wire logic [fps_pkg::NCH-1:0] gate_low_i,
  input wire logic kill_in_i,
  output logic kill_o,
  output logic kill_oe_o,
  output logic [fps_pkg::NCH-1:0] gate_on_o,
  output logic [1:0] done_n_o,
  output logic sleep_o,
  input wire logic [fps_pkg::AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [fps_pkg::AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import fps_pkg::*;

  logic [CTRL_W-1:0] ctrl_q;
  logic [DLY_W-1:0] on_dly_q [NCH];
  logic [DLY_W-1:0] off_dly_q [NCH];
  fps_state_t st_q, st_d;
  logic [CNT_W-1:0] cnt_q;
  logic [7:0] tick_q;
  logic [NCH-1:0] gate_q, gate_d, uv_bad;
  logic [1:0] lock_q, done_n_q;
  logic kill_drv_q, kill_prev_q, sleep_q;

  wire fps_mode_t mode = fps_mode_t'(ctrl_q[1:0]);
  wire is_grp = mode == MODE_GROUPS;
  wire is_ind = mode == MODE_INDEP;
  wire is_fix = mode == MODE_FIXED;
  // Polarity bit set selects an active-low enable
  wire [1:0] en_ok = ctrl_q[CTRL_POL_BIT] ? ~enable_i : enable_i;
  wire en_all = is_grp ? &en_ok : en_ok[0];
  wire all_ok = &uv_ok_i & en_all;
  wire kill_low = ~kill_in_i;
  wire fast = kill_in_i & ~kill_prev_q;
  wire tick = tick_q == 8'(TICK_CYC - 1);
  wire after_on = st_q == ST_STAB || st_q == ST_RUN;
  wire glob_fault = after_on & |uv_bad & ~is_grp & ~is_ind;
  wire [1:0] grp_bad = {|uv_bad[3:2], |uv_bad[1:0]};
  wire all_full = &(gate_q & gate_full_i);
  wire stab_end = cnt_q == CNT_W'((is_ind ? IND_DONE_CYC_P : DONE_CYC_P) - 1);
  wire settle_end = cnt_q == CNT_W'(SETTLE_CYC_P - 1);
  wire [NCH-1:0] full_sh = {gate_full_i[2:0], 1'b1};
  wire [NCH-1:0] low_sh = {1'b1, gate_low_i[3:1]};
  wire [NCH-1:0] low_gsh = {1'b1, gate_low_i[3], 1'b1, gate_low_i[1]};

  // Monitor glitch filter, turn-on and turn-off timers per rail
  genvar i;
  generate
    for (i = 0; i < NCH; i++) begin : g_ch
      logic [CNT_W-1:0] flt_q;
      logic [DLY_W-1:0] on_cnt_q, off_cnt_q;
      wire en_ch = is_grp ? en_ok[i/2] : en_ok[0];
      wire arm_on = st_q == ST_ON && ~is_ind && ~gate_q[i] && (mode == MODE_TIMED || full_sh[i]);
      wire off_req = is_grp ? ~en_ch : st_q == ST_OFF;
      wire ord_ok = is_fix ? low_sh[i] : (is_grp ? low_gsh[i] : 1'b1);
      wire arm_off = off_req && gate_q[i] && ord_ok;
      wire [DLY_W-1:0] on_lim = is_fix ? '0 : on_dly_q[i];
      wire [DLY_W-1:0] off_lim = is_fix ? '0 : off_dly_q[i];
      wire hit_on = arm_on && on_cnt_q >= on_lim;
      wire hit_off = arm_off && off_cnt_q >= off_lim;
      assign uv_bad[i] = flt_q == CNT_W'(FILTER_CYC_P);
      always_comb begin
        gate_d[i] = gate_q[i];
        if (kill_low || glob_fault || (is_grp && lock_q[i/2])) begin
          gate_d[i] = 1'b0;
        end else if (is_ind && en_ch && st_q != ST_OFF && st_q != ST_IDLE) begin
          // Enable loss holds the drives so the off timers decide
          gate_d[i] = uv_ok_i[i];
        end else if (hit_on) begin
          gate_d[i] = 1'b1;
        end else if (hit_off) begin
          gate_d[i] = 1'b0;
        end
      end
      // Timers restart from zero whenever they are not armed
      always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          flt_q <= '0;
          on_cnt_q <= '0;
          off_cnt_q <= '0;
        end else begin
          flt_q <= uv_ok_i[i] ? '0 : (uv_bad[i] ? flt_q : flt_q + 1'b1);
          on_cnt_q <= !arm_on ? '0 : on_cnt_q + DLY_W'(tick);
          off_cnt_q <= !arm_off ? '0 : off_cnt_q + DLY_W'(tick);
        end
      end
    end
  endgenerate

  // Sequencing state
  always_comb begin
    st_d = st_q;
    case (st_q)
      ST_IDLE: begin
        if (is_ind ? en_ok[0] : all_ok) begin
          st_d = (fast || is_ind) ? ST_ON : ST_SETTLE;
        end
      end
      ST_SETTLE: begin
        if (!all_ok) begin
          st_d = ST_IDLE;
        end else if (settle_end || fast) begin
          st_d = ST_ON;
        end
      end
      ST_ON: begin
        if (!en_all) begin
          st_d = is_grp ? ST_RUN : ST_OFF;
        end else if (all_full) begin
          st_d = ST_STAB;
        end
      end
      ST_STAB: begin
        if (!en_all) begin
          st_d = is_grp ? ST_RUN : ST_OFF;
        end else if (is_ind && !all_full) begin
          st_d = ST_ON;
        end else if (stab_end) begin
          st_d = ST_RUN;
        end
      end
      ST_RUN: begin
        if (is_grp) begin
          if (gate_q == '0 && !all_ok) begin
            st_d = ST_IDLE;
          end else if (gate_q != '1 && all_ok && lock_q == '0) begin
            st_d = ST_SETTLE;
          end
        end else if (!en_ok[0]) begin
          st_d = ST_OFF;
        end else if (is_ind && !all_full) begin
          st_d = ST_ON;
        end
      end
      ST_OFF: begin
        if (gate_q == '0) begin
          st_d = ST_IDLE;
        end
      end
      default: st_d = ST_IDLE;
    endcase
    if (kill_low || glob_fault) begin
      st_d = ST_IDLE;
    end
  end

  wire run_next = st_d == ST_RUN;
  wire [1:0] done_ok = is_grp ? ({2{run_next}} & en_ok & ~lock_q & ~grp_bad) : {2{run_next}};

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_q <= ST_IDLE;
      cnt_q <= '0;
      tick_q <= '0;
      gate_q <= '0;
      lock_q <= '0;
      done_n_q <= '0;
      kill_drv_q <= 1'b0;
      kill_prev_q <= 1'b1;
      sleep_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= (st_d != st_q) ? '0 : cnt_q + 1'b1;
      tick_q <= tick ? '0 : tick_q + 1'b1;
      gate_q <= gate_d;
      done_n_q <= (kill_low || glob_fault) ? 2'h0 : done_ok;
      // Lock clears once that group's enable goes away; a fault in that cycle wins
      lock_q <= is_grp ? ((lock_q & en_ok) | ({2{after_on}} & grp_bad)) : 2'h0;
      kill_drv_q <= glob_fault | (kill_drv_q & |uv_bad);
      kill_prev_q <= kill_in_i;
      sleep_q <= mode == MODE_TIMED && !ctrl_q[CTRL_POL_BIT] && !enable_i[0]
                 && st_d == ST_IDLE;
    end
  end

  assign kill_o = 1'b0;
  assign kill_oe_o = kill_drv_q;
  assign gate_on_o = gate_q;
  assign done_n_o = done_n_q;
  assign sleep_o = sleep_q;

  // AXI4-Lite slave; address and data may arrive in either order
  logic aw_rdy_q, w_rdy_q, aw_have_q, w_have_q, bvalid_q, ar_rdy_q, rvalid_q;
  logic [AW-1:0] waddr_q;
  logic [31:0] wdata_q, rdata_q;
  logic [3:0] wstrb_q;
  logic [1:0] bresp_q, rresp_q;

  wire aw_fire = s_axi_awvalid & aw_rdy_q;
  wire w_fire = s_axi_wvalid & w_rdy_q;
  wire wr_do = aw_have_q & w_have_q & ~bvalid_q;
  wire ar_fire = s_axi_arvalid & ar_rdy_q;
  wire [31:0] wmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
  wire [1:0] wch = waddr_q[3:2];
  wire [1:0] rch = s_axi_araddr[3:2];
  wire w_ctrl = waddr_q == CTRL_OFS;
  wire w_on = waddr_q[7:4] == ON_PAGE;
  wire w_off = waddr_q[7:4] == OFF_PAGE;
  wire w_map = w_ctrl | w_on | w_off | waddr_q == STAT_OFS;
  wire [31:0] stat_w = 32'({st_q, lock_q, kill_drv_q, done_n_q, gate_q});
  wire r_ctrl = s_axi_araddr == CTRL_OFS;
  wire r_stat = s_axi_araddr == STAT_OFS;
  wire r_on = s_axi_araddr[7:4] == ON_PAGE;
  wire r_off = s_axi_araddr[7:4] == OFF_PAGE;
  wire r_map = r_ctrl | r_stat | r_on | r_off;
  wire [31:0] r_val = r_ctrl ? 32'(ctrl_q) : r_stat ? stat_w :
                      r_on ? 32'(on_dly_q[rch]) : r_off ? 32'(off_dly_q[rch]) : 32'h0;
  wire [31:0] old_w = w_ctrl ? 32'(ctrl_q) : w_on ? 32'(on_dly_q[wch]) : 32'(off_dly_q[wch]);
  wire [31:0] new_w = (old_w & ~wmask) | (wdata_q & wmask);

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      aw_rdy_q <= 1'b0;
      w_rdy_q <= 1'b0;
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OK;
      waddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
    end else begin
      if (aw_fire) begin
        aw_rdy_q <= 1'b0;
        aw_have_q <= 1'b1;
        waddr_q <= s_axi_awaddr;
      end else if (!aw_have_q && !bvalid_q && !wr_do) begin
        aw_rdy_q <= 1'b1;
      end
      if (w_fire) begin
        w_rdy_q <= 1'b0;
        w_have_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end else if (!w_have_q && !bvalid_q && !wr_do) begin
        w_rdy_q <= 1'b1;
      end
      if (wr_do) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= w_map ? RESP_OK : RESP_ERR;
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // Status writes are accepted and dropped
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl_q <= CTRL_RST;
      for (int k = 0; k < NCH; k++) begin
        on_dly_q[k] <= '0;
        off_dly_q[k] <= '0;
      end
    end else if (wr_do) begin
      if (w_ctrl) ctrl_q <= new_w[CTRL_W-1:0];
      if (w_on) on_dly_q[wch] <= new_w[DLY_W-1:0];
      if (w_off) off_dly_q[wch] <= new_w[DLY_W-1:0];
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ar_rdy_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= RESP_OK;
    end else if (ar_fire) begin
      ar_rdy_q <= 1'b0;
      rvalid_q <= 1'b1;
      rdata_q <= r_val;
      rresp_q <= r_map ? RESP_OK : RESP_ERR;
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q <= 1'b0;
    end else if (!rvalid_q) begin
      ar_rdy_q <= 1'b1;
    end
  end

  assign s_axi_awready = aw_rdy_q;
  assign s_axi_wready = w_rdy_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = ar_rdy_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  sequence s_kill_hit;
    !kill_in_i;
  endsequence
  sequence s_fixed_next;
    is_fix && $rose(gate_on_o[1]);
  endsequence

  a_kill_gates_off: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    s_kill_hit |=> gate_on_o == '0 && done_n_o == 2'h0)
    else $error("kill line low left a drive on");
  a_fault_kills_all: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    glob_fault |=> kill_oe_o && gate_on_o == '0 ##1 st_q == ST_IDLE || kill_low)
    else $error("fault did not kill drives");
  a_done_all_full: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    !is_grp && $rose(done_n_o[0]) |-> $past(all_full) && done_n_o[1])
    else $error("done released without full drives");
  a_fixed_order_on: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    s_fixed_next |-> $past(gate_full_i[0]) && gate_on_o[0])
    else $error("fixed order skipped a rail");
  a_fixed_order_off: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    is_fix && st_q == ST_OFF && $fell(gate_on_o[2]) && kill_in_i |-> $past(gate_low_i[3]))
    else $error("fixed order off out of turn");
  a_settle_first: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    mode == MODE_TIMED && st_q == ST_SETTLE && st_d == ST_ON && !fast |-> settle_end)
    else $error("turn-on started before settle");
  a_sleep_idle: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    sleep_o |-> st_q == ST_IDLE && gate_on_o == '0 || $past(st_q) == ST_IDLE)
    else $error("sleep while sequencing");
  a_group_lock: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    is_grp && lock_q[0] |=> gate_on_o[1:0] == 2'h0 && done_n_o[0] == 1'b0)
    else $error("locked group still active");
  a_kill_drive_hold: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    kill_oe_o && |uv_bad |=> kill_oe_o)
    else $error("kill drive released during fault");
endmodule // fps_sequencer

// >>> shared/fps_pkg.sv
// Purpose: Constants and types for the four rail power sequencer.
// Assumes: 200 MHz core clock, registers on AXI4-Lite.
// Notes: Timing counts are core clock cycles unless named in ms or us.
// How it works
// - Timed start after enable and monitors settle
// - Each rail on when own delay expires
// - Done released after full-on plus stability
// - Filtered monitor fault kills everything at once
// - Disable drops done, rails off by timers
// - Either enable polarity; active-high variant sleeps
// - Independent channels follow own monitor
// - Independent drop only lowers done
// - Fixed order A to D, previous full
// - Fixed order fault drops all rails
// - Fixed order off D to A, previous low
// - Two groups, both enables, ordered turn-on
// - Group done released after D full
// - Group fault latches until enable cycles
// - Group turn-off in reverse order
// - Kill line low shuts everything down
// - Kill line release skips settle time
// - Device drives kill line on fault in timed and fixed order modes
// - Automatic restart outside group mode
// - Zero delay switches immediately
// - Off delay from disable, linear scale
package fps_pkg;
  localparam int CLK_MHZ = 200;
  localparam int SETTLE_MS = 10;
  localparam int DONE_MS = 160;
  localparam int IND_DONE_MS = 150;
  localparam int FILTER_US = 30;
  localparam int TICK_US = 1;
  localparam int SETTLE_CYC = SETTLE_MS * 1000 * CLK_MHZ;
  localparam int DONE_CYC = DONE_MS * 1000 * CLK_MHZ;
  localparam int IND_DONE_CYC = IND_DONE_MS * 1000 * CLK_MHZ;
  localparam int FILTER_CYC = FILTER_US * CLK_MHZ;
  localparam int TICK_CYC = TICK_US * CLK_MHZ;
  localparam int NCH = 4;
  localparam int DLY_W = 24;
  localparam int CNT_W = 26;
  localparam int AW = 8;
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STAT_OFS = 8'h04;
  localparam logic [3:0] ON_PAGE = 4'h1;
  localparam logic [3:0] OFF_PAGE = 4'h2;
  localparam int CTRL_W = 3;
  localparam int CTRL_POL_BIT = 2;
  localparam logic [2:0] CTRL_RST = 3'h0;
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;
  typedef enum logic [1:0] {MODE_TIMED, MODE_INDEP, MODE_FIXED, MODE_GROUPS} fps_mode_t;
  typedef enum logic [2:0] {ST_IDLE, ST_SETTLE, ST_ON, ST_STAB, ST_RUN, ST_OFF} fps_state_t;
endpackage

// >>> testbench/fps_rail_model.sv
// Purpose: Rail switches and shared kill wire seen from the sequencer.
// Assumes: Each drive ramps between off and full in RAMP cycles.
// Notes: Kill wire has a pull-up, so it reads high unless someone pulls it.
`timescale 1ns/1ps
module fps_rail_model #(
  parameter int RAMP = 10
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic [3:0] gate_on_i,
  input wire logic kill_oe_i,
  input wire logic ext_kill_i,
  output logic [3:0] full_o,
  output logic [3:0] low_o,
  output logic kill_w_o
);
  int lvl [4];
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    for (int i = 0; i < 4; i++) begin
      if (!rst_n_i) lvl[i] <= 0;
      else if (gate_on_i[i] && lvl[i] < RAMP) lvl[i] <= lvl[i] + 1;
      else if (!gate_on_i[i] && lvl[i] > 0) lvl[i] <= lvl[i] - 1;
    end
  end
  // Slow ramp both ways, so ordering that waits on feedback is visible
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      full_o[i] = (lvl[i] == RAMP);
      low_o[i] = (lvl[i] == 0);
    end
  end
  assign kill_w_o = !(kill_oe_i || ext_kill_i);
endmodule // fps_rail_model

// >>> testbench/tb.sv
// Purpose: Self-checking bench for the four rail sequencer.
// Assumes: Shortened count parameters; rails ramp in 10 cycles.
// Notes: Delays are 1 us ticks of 200 cycles; every mode is driven.
`timescale 1ns/1ps
module tb;
  import fps_pkg::*;
  localparam int RAMP = 10;
  localparam int SET = 50;
  localparam int DON = 60;
  localparam int IND = 50;
  localparam int FIL = 8;
  logic clk, rst_n, ext_kill, kin, koe, ko, slp, dn_q;
  logic [3:0] uv, gf, gl, gon, gon_q, full_q, wstrb;
  logic [1:0] en, dn, rsp, bresp, rresp;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  int cyc, tf, td, t0, miscompares, n_checks;
  int on_t [4];
  int off_t [4];
  int ond [4] = '{2, 0, 3, 1};
  int offd [4] = '{0, 3, 1, 2};
  fps_sequencer #(.SETTLE_CYC_P(SET), .DONE_CYC_P(DON), .IND_DONE_CYC_P(IND),
    .FILTER_CYC_P(FIL)) dut_u (.core_clk_i(clk), .rst_n_i(rst_n), .uv_ok_i(uv),
    .enable_i(en), .gate_full_i(gf), .gate_low_i(gl), .kill_in_i(kin), .kill_o(ko),
    .kill_oe_o(koe), .gate_on_o(gon), .done_n_o(dn), .sleep_o(slp),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  fps_rail_model #(.RAMP(RAMP)) mdl_u (.core_clk_i(clk), .rst_n_i(rst_n), .gate_on_i(gon),
    .kill_oe_i(koe), .ext_kill_i(ext_kill), .full_o(gf), .low_o(gl), .kill_w_o(kin));
  // Edge times of drives, full and done, for order and spacing checks
  always @(posedge clk) begin
    cyc <= cyc + 1;
    for (int i = 0; i < 4; i++) begin
      if (gon[i] && !gon_q[i]) on_t[i] = cyc;
      if (!gon[i] && gon_q[i]) off_t[i] = cyc;
    end
    if (&gf && !(&full_q)) tf = cyc;
    if (dn[0] && !dn_q) td = cyc;
    gon_q = gon;
    full_q = gf;
    dn_q = dn[0];
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cyc_n(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Bus waits have no limit of their own; the watchdog ends a hang
  task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
    @(posedge clk);
  endtask
  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wg(input logic [3:0] v, input int lim);
    int n;
    n = 0;
    while (gon !== v && n < lim) begin
      @(posedge clk);
      n++;
    end
    chk("gates", v, gon);
  endtask
  task automatic wd(input int gap);
    int n;
    n = 0;
    while (dn[0] !== 1'b1 && n < 3000) begin
      @(posedge clk);
      n++;
    end
    chk("done_up", 1'b1, dn[0]);
    cyc_n(2);
    chk("done_gap", 1'b1, (td - tf) inside {[gap - 2:gap + 3]});
  endtask
  task automatic close_out;
    if (miscompares == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Whole run is about 6k cycles; a hang is cut well beyond that
  initial begin
    #400000;
    miscompares++;
    close_out;
  end
  initial begin
    {rst_n, ext_kill, awvalid, wvalid, bready, arvalid, rready} = '0;
    {uv, en, awaddr, araddr, wdata, gon_q, full_q, dn_q} = '0;
    wstrb = 4'hf;
    cyc_n(2);
    rst_n <= 1'b1;
    cyc_n(2);
    chk("gates_rst", 4'h0, gon);
    chk("done_rst", 2'h0, dn);
    chk("sleep_idle", 1'b1, slp);
    axr(CTRL_OFS, rd, rsp);
    chk("ctrl_rst", {29'h0, CTRL_RST}, rd);
    axr(8'h0c, rd, rsp);
    chk("unmapped_rd", RESP_ERR, rsp);
    axw(8'h0c, 32'h1, rsp);
    chk("unmapped_wr", RESP_ERR, rsp);
    for (int i = 0; i < 4; i++) begin
      axw(8'h10 + 8'(4 * i), 32'(ond[i]), rsp);
      axw(8'h20 + 8'(4 * i), 32'(offd[i]), rsp);
    end
    axr(8'h18, rd, rsp);
    chk("on_dly_rd", 32'h3, rd);
    uv <= 4'hf;
    en <= 2'h1;
    t0 = cyc;
    wg(4'hf, 2000);
    wd(DON);
    chk("settle", 1'b1, (on_t[1] - t0) inside {[SET:SET + 8]});
    chk("on_order", 1'b1, on_t[1] < on_t[3] && on_t[3] < on_t[0] && on_t[0] < on_t[2]);
    chk("on_span", 1'b1, (on_t[2] - on_t[0]) inside {[199:201]});
    axr(STAT_OFS, rd, rsp);
    chk("status_run", 32'h83f, rd);
    uv <= 4'hb;
    cyc_n(FIL - 4);
    uv <= 4'hf;
    cyc_n(4);
    chk("glitch", 4'hf, gon);
    uv <= 4'hb;
    cyc_n(FIL + 4);
    chk("fault_gates", 4'h0, gon);
    chk("fault_kill", 1'b1, koe);
    chk("kill_data", 1'b0, ko);
    chk("fault_done", 2'h0, dn);
    chk("fault_same", 1'b1, off_t[0] == off_t[1] && off_t[1] == off_t[2] && off_t[2] == off_t[3]);
    uv <= 4'hf;
    wg(4'hf, 2000);
    wd(DON);
    chk("kill_free", 1'b0, koe);
    ext_kill <= 1'b1;
    cyc_n(3);
    chk("kill_gates", 4'h0, gon);
    chk("kill_done", 2'h0, dn);
    cyc_n(5);
    ext_kill <= 1'b0;
    t0 = cyc;
    wg(4'hf, 2000);
    chk("fast_start", 1'b1, on_t[1] - t0 < SET);
    wd(DON);
    en <= 2'h0;
    t0 = cyc;
    cyc_n(3);
    chk("off_done", 2'h0, dn);
    wg(4'h0, 2000);
    cyc_n(3);
    chk("off_order", 1'b1, off_t[0] < off_t[2] && off_t[2] < off_t[3] && off_t[3] < off_t[1]);
    chk("off_zero", 1'b1, off_t[0] - t0 <= 4);
    chk("sleep_dis", 1'b1, slp);
    uv <= 4'h0;
    en <= 2'h3;
    axw(CTRL_OFS, 32'h6, rsp);
    chk("sleep_low_pol", 1'b0, slp);
    uv <= 4'hf;
    en <= 2'h0;
    wg(4'hf, 2000);
    wd(DON);
    chk("fix_order", 1'b1, on_t[1] - on_t[0] >= RAMP && on_t[2] - on_t[1] >= RAMP
      && on_t[3] - on_t[2] >= RAMP);
    uv <= 4'h7;
    cyc_n(FIL + 4);
    chk("fix_fault", 4'h0, gon);
    chk("fix_kill", 1'b1, koe);
    uv <= 4'hf;
    wg(4'hf, 2000);
    wd(DON);
    en <= 2'h3;
    wg(4'h0, 500);
    cyc_n(3);
    chk("fix_off", 1'b1, off_t[2] - off_t[3] >= RAMP && off_t[1] - off_t[2] >= RAMP
      && off_t[0] - off_t[1] >= RAMP);
    uv <= 4'h1;
    axw(CTRL_OFS, 32'h5, rsp);
    en <= 2'h0;
    wg(4'h1, 50);
    uv <= 4'hf;
    wg(4'hf, 50);
    wd(IND);
    uv <= 4'h7;
    cyc_n(FIL + 4);
    chk("ind_keep", 3'h7, gon[2:0]);
    chk("ind_done", 1'b0, dn[0]);
    en <= 2'h3;
    wg(4'h0, 2000);
    cyc_n(3);
    chk("ind_off", 1'b1, off_t[0] < off_t[2] && off_t[2] < off_t[1]);
    axw(CTRL_OFS, 32'h7, rsp);
    uv <= 4'hf;
    en <= 2'h0;
    wg(4'hf, 3000);
    wd(DON);
    uv <= 4'hd;
    cyc_n(FIL + 4);
    chk("grp_keep", 4'hc, gon);
    chk("grp_done", 2'h2, dn);
    uv <= 4'hf;
    cyc_n(20);
    chk("grp_lock", 4'hc, gon);
    en <= 2'h1;
    cyc_n(2);
    en <= 2'h0;
    wg(4'hf, 2000);
    wd(DON);
    en <= 2'h3;
    wg(4'h0, 2000);
    cyc_n(3);
    chk("grp_off", 1'b1, off_t[1] < off_t[0] && off_t[3] < off_t[2]);
    close_out;
  end
endmodule // tb
